/* File: design/setpoint_ramp_consts.vh */
// constants for the pushbutton setpoint ramp: offsets, resets, timing
`ifndef SETPOINT_RAMP_CONSTS_VH
`define SETPOINT_RAMP_CONSTS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define PCLK_HZ 10000000
`define MS_PER_S 1000
`define CYC_PER_MS (`PCLK_HZ / `MS_PER_S)
`define DEBOUNCE_MS 10
`define COMBO_HOLD_S 1
`define NV_IDLE_S 60
`define RAMP_MAX_S 60
`define RAMP_MAX_MS 16'hea60

// ----------------------------------------
// level format
// ----------------------------------------
`define LVL_W 16
`define LVL_FULL 16'hffff
`define FLOOR_SHIFT_V 2
`define FLOOR_SHIFT_I 2

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_RISE 8'h04
`define REG_FALL 8'h08
`define REG_FLOOR 8'h0c
`define REG_CEIL 8'h10
`define REG_STATUS 8'h14
`define REG_LEVEL 8'h18
`define REG_HELD 8'h1c
`define REG_OUT 8'h20

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define CTRL_EXT_EN 0
`define CTRL_RST 1'b0
`define RISE_RST 16'h2710
`define FALL_RST 16'h2710
`define FLOOR_RST 16'h0000
`define CEIL_RST 16'hffff

`endif

/* File: design/contact_debounce.v */
// two-flop synchroniser and stability filter for one contact pin
`timescale 1ns/1ps
module contact_debounce #(
	parameter CNT_W = 20,
	parameter STABLE_CYCLES = 100000
) (
	input wire pclk, // system clock
	input wire presetn, // async reset, active low
	input wire raw, // contact pin, asynchronous
	output reg clean_ff // filtered level
);
	localparam [31:0] LAST_I = STABLE_CYCLES - 1;
	localparam [CNT_W-1:0] LAST = LAST_I[CNT_W-1:0];
	reg sync1_ff;
	reg sync2_ff;
	reg [CNT_W-1:0] cnt_ff;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			cnt_ff <= {CNT_W{1'b0}};
			clean_ff <= 1'b0;
		end
		else
		begin
			sync1_ff <= raw;
			sync2_ff <= sync1_ff;
			// new level must hold steady for the whole window
			if (sync2_ff == clean_ff)
				cnt_ff <= {CNT_W{1'b0}};
			else if (cnt_ff == LAST)
			begin
				cnt_ff <= {CNT_W{1'b0}};
				clean_ff <= sync2_ff;
			end
			else
				cnt_ff <= cnt_ff + 1'b1;
		end
	end
endmodule

/* File: design/ramp_rate_gen.v */
// step enable generator: full scale in time_ms milliseconds, linear
`timescale 1ns/1ps
`include "setpoint_ramp_consts.vh"
module ramp_rate_gen (
	input wire pclk, // system clock
	input wire presetn, // async reset, active low
	input wire run, // ramp active
	input wire [15:0] time_ms, // full-scale ramp time in ms
	output reg step_ff // one-cycle step enable
);
	localparam [31:0] CPM_I = `CYC_PER_MS;
	localparam [13:0] CPM = CPM_I[13:0];
	wire [29:0] period = {14'h0, time_ms} * {16'h0, CPM};
	reg [30:0] acc_ff;
	wire [30:0] sum = acc_ff + {15'h0, `LVL_FULL};
	wire hit = (sum >= {1'b0, period});

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc_ff <= 31'h0;
			step_ff <= 1'b0;
		end
		else if (!run)
		begin
			acc_ff <= 31'h0;
			step_ff <= 1'b0;
		end
		else
		begin
			step_ff <= hit;
			// at one code per clock or faster the ramp saturates at the clock rate
			if (period <= {14'h0, `LVL_FULL})
				acc_ff <= 31'h0;
			else if (hit)
				acc_ff <= sum - {1'b0, period};
			else
				acc_ff <= sum;
		end
	end
endmodule

/* File: design/pushbutton_setpoint_ramp.v */
// pushbutton setpoint ramp: contacts, ramps, limits, scaling, memory, apb
`timescale 1ns/1ps
`include "setpoint_ramp_consts.vh"

// Function
// - raise/lower act only while enabled
// - enable open ramps down to floor
// - enable close ramps back to held value
// - raise held increases at rise rate
// - lower held decreases at fall rate
// - both held one second: instant minimum
// - combination reset works regardless of enable
// - all changes except the combination reset are linear ramps, max 60s
// - rise time full scale, 0 to 60s
// - fall time full scale, 0 to 60s
// - ceiling limits and stops increase
// - floor is minimum; ramps end there
// - output is fraction of external reference
// - jumper selects type; floor range shifted by 2 for either type
// - memory write after one minute unchanged
// - restore stored value as target at power-up
module pushbutton_setpoint_ramp #(
	parameter DEBOUNCE_CYCLES = `DEBOUNCE_MS * `CYC_PER_MS,
	parameter DEBOUNCE_W = 20,
	parameter COMBO_CYCLES = `COMBO_HOLD_S * `PCLK_HZ,
	parameter COMBO_W = 24,
	parameter NV_IDLE_CYCLES = `NV_IDLE_S * `PCLK_HZ,
	parameter NV_W = 30
) (
	input wire pclk, // system clock, 10 MHz
	input wire presetn, // async reset, active low
	input wire [7:0] paddr, // apb byte address
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb write
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata_ff, // apb read data
	output reg pready_ff, // apb ready
	output reg pslverr_ff, // apb error, unmapped address
	input wire raise_contact, // raise contact, high when closed
	input wire lower_contact, // lower contact, high when closed
	input wire enable_contact, // enable contact, high when closed
	input wire output_type_jumper, // 1 = current, 0 = voltage
	input wire [15:0] external_scale_input, // external reference level
	input wire nv_restore_valid, // one-cycle pulse, restored value valid
	input wire [15:0] nv_restore_data, // restored setpoint
	output reg [15:0] setpoint_out_ff, // level to output converter
	output reg output_type_ff, // type sent to output stage
	output reg nv_write_req_ff, // one-cycle memory write request
	output reg [15:0] nv_write_data_ff // value to store
);
	// ----------------------------------------
	// contact inputs
	// ----------------------------------------
	// the jumper is a strap but is filtered like a contact
	wire [3:0] pin_raw = {output_type_jumper, enable_contact, lower_contact, raise_contact};
	wire [3:0] pin_db;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_pin
			contact_debounce #(
				.CNT_W(DEBOUNCE_W),
				.STABLE_CYCLES(DEBOUNCE_CYCLES)
			) u_db (
				.pclk(pclk),
				.presetn(presetn),
				.raw(pin_raw[gi]),
				.clean_ff(pin_db[gi])
			);
		end
	endgenerate
	wire raise_db = pin_db[0];
	wire lower_db = pin_db[1];
	wire en_db = pin_db[2];
	wire type_db = pin_db[3];

	// ----------------------------------------
	// settings registers
	// ----------------------------------------
	reg ctrl_ff;
	reg [15:0] rise_ff;
	reg [15:0] fall_ff;
	reg [15:0] floor_ff;
	reg [15:0] ceil_ff;
	reg [15:0] held_ff;
	reg [15:0] level_ff;

	// ----------------------------------------
	// limits
	// ----------------------------------------
	wire [15:0] floor_v = floor_ff >> `FLOOR_SHIFT_V;
	wire [15:0] floor_i = floor_ff >> `FLOOR_SHIFT_I;
	wire [15:0] lo = type_db ? floor_i : floor_v;
	// a ceiling below the floor collapses the range onto the floor
	wire [15:0] hi = (ceil_ff < lo) ? lo : ceil_ff;
	wire [15:0] held_clamp = (held_ff > hi) ? hi : ((held_ff < lo) ? lo : held_ff);
	// a restored value outside the limits is pulled inside
	wire [15:0] rest_clamp = (nv_restore_data > hi) ? hi :
		((nv_restore_data < lo) ? lo : nv_restore_data);

	// ----------------------------------------
	// contact decode and combination reset
	// ----------------------------------------
	// both closed blocks either ramp for as long as both stay closed
	wire both = raise_db & lower_db;
	wire raise_on = raise_db & ~lower_db & en_db;
	wire lower_on = lower_db & ~raise_db & en_db;
	localparam [31:0] COMBO_LAST_I = COMBO_CYCLES - 1;
	localparam [COMBO_W-1:0] COMBO_LAST = COMBO_LAST_I[COMBO_W-1:0];
	reg [COMBO_W-1:0] combo_cnt_ff;
	reg combo_done_ff;
	wire combo_fire = both & ~combo_done_ff & (combo_cnt_ff == COMBO_LAST);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			combo_cnt_ff <= {COMBO_W{1'b0}};
			combo_done_ff <= 1'b0;
		end
		else if (!both)
		begin
			// either contact opening restarts the hold time
			combo_cnt_ff <= {COMBO_W{1'b0}};
			combo_done_ff <= 1'b0;
		end
		else
		begin
			if (combo_cnt_ff != COMBO_LAST)
				combo_cnt_ff <= combo_cnt_ff + 1'b1;
			if (combo_fire)
				combo_done_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// ramp rate generators
	// ----------------------------------------
	// held is the operator target, level is what leaves the block
	wire [15:0] target = en_db ? held_ff : lo;
	wire go_up = (level_ff < target);
	wire go_down = (level_ff > target);
	wire rise_step;
	wire fall_step;

	// one generator per direction so each keeps its own phase
	ramp_rate_gen u_rise (
		.pclk(pclk),
		.presetn(presetn),
		.run(raise_on | go_up),
		.time_ms(rise_ff),
		.step_ff(rise_step)
	);

	ramp_rate_gen u_fall (
		.pclk(pclk),
		.presetn(presetn),
		.run(lower_on | go_down),
		.time_ms(fall_ff),
		.step_ff(fall_step)
	);

	// ----------------------------------------
	// held setpoint and ramped level
	// ----------------------------------------
	// combination reset beats restore, restore beats the contacts
	reg [15:0] nxt_held;
	reg [15:0] nxt_level;

	always @*
	begin
		nxt_held = held_clamp;
		if (combo_fire)
			nxt_held = lo;
		else if (nv_restore_valid)
			nxt_held = rest_clamp;
		else if (raise_on && rise_step && held_clamp < hi)
			nxt_held = held_clamp + 16'h0001;
		else if (lower_on && fall_step && held_clamp > lo)
			nxt_held = held_clamp - 16'h0001;
	end

	always @*
	begin
		nxt_level = level_ff;
		if (combo_fire)
			nxt_level = lo;
		else if (go_up && rise_step)
			nxt_level = level_ff + 16'h0001;
		else if (go_down && fall_step)
			nxt_level = level_ff - 16'h0001;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			held_ff <= 16'h0000;
			level_ff <= 16'h0000;
		end
		else
		begin
			held_ff <= nxt_held;
			level_ff <= nxt_level;
		end
	end

	// ----------------------------------------
	// output scaling
	// ----------------------------------------
	// full product kept; only the top half reaches the output
	wire [31:0] scaled = {16'h0, level_ff} * {16'h0, external_scale_input};

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			setpoint_out_ff <= 16'h0000;
			output_type_ff <= 1'b0;
		end
		else
		begin
			// full-scale level passes nearly all of the reference
			setpoint_out_ff <= ctrl_ff ? scaled[31:16] : level_ff;
			output_type_ff <= type_db;
		end
	end

	// ----------------------------------------
	// non-volatile save after idle minute
	// ----------------------------------------
	localparam [31:0] NV_LAST_I = NV_IDLE_CYCLES - 1;
	localparam [NV_W-1:0] NV_LAST = NV_LAST_I[NV_W-1:0];
	reg [NV_W-1:0] nv_cnt_ff;
	reg [15:0] nv_prev_ff;
	// saved copy stops rewrites of an unchanged value
	reg [15:0] nv_saved_ff;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			nv_cnt_ff <= {NV_W{1'b0}};
			nv_prev_ff <= 16'h0000;
			nv_saved_ff <= 16'h0000;
			nv_write_req_ff <= 1'b0;
			nv_write_data_ff <= 16'h0000;
		end
		else
		begin
			nv_prev_ff <= held_ff;
			nv_write_req_ff <= 1'b0;
			if (nv_restore_valid)
			begin
				// restored value is already stored, no rewrite needed
				nv_saved_ff <= rest_clamp;
				nv_cnt_ff <= {NV_W{1'b0}};
			end
			else if (held_ff != nv_prev_ff)
				nv_cnt_ff <= {NV_W{1'b0}};
			else if (nv_cnt_ff != NV_LAST)
				nv_cnt_ff <= nv_cnt_ff + 1'b1;
			else if (held_ff != nv_saved_ff)
			begin
				nv_write_req_ff <= 1'b1;
				nv_write_data_ff <= held_ff;
				nv_saved_ff <= held_ff;
			end
		end
	end

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	// read data is latched at setup so the access sees it steady
	wire setup = psel & ~penable;
	wire wr_en = psel & penable & pready_ff & pwrite;
	wire [15:0] wd = pwdata[15:0];
	wire [15:0] wd_time = (wd > `RAMP_MAX_MS) ? `RAMP_MAX_MS : wd;
	reg [31:0] rd_mux;
	reg rd_err;

	always @*
	begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr)
			`REG_CTRL: rd_mux = {31'h0, ctrl_ff};
			`REG_RISE: rd_mux = {16'h0, rise_ff};
			`REG_FALL: rd_mux = {16'h0, fall_ff};
			`REG_FLOOR: rd_mux = {16'h0, floor_ff};
			`REG_CEIL: rd_mux = {16'h0, ceil_ff};
			`REG_STATUS: rd_mux = {27'h0, both, type_db, en_db, lower_db, raise_db};
			`REG_LEVEL: rd_mux = {16'h0, level_ff};
			`REG_HELD: rd_mux = {16'h0, held_ff};
			`REG_OUT: rd_mux = {16'h0, setpoint_out_ff};
			default: rd_err = 1'b1;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			ctrl_ff <= `CTRL_RST;
			rise_ff <= `RISE_RST;
			fall_ff <= `FALL_RST;
			floor_ff <= `FLOOR_RST;
			ceil_ff <= `CEIL_RST;
		end
		else
		begin
			// no wait state: ready rises for the first access cycle
			pready_ff <= setup;
			if (setup)
			begin
				pslverr_ff <= rd_err;
				prdata_ff <= (pwrite || rd_err) ? 32'h0000_0000 : rd_mux;
			end
			else if (pready_ff)
			begin
				pslverr_ff <= 1'b0;
				prdata_ff <= 32'h0000_0000;
			end
			if (wr_en)
			begin
				case (paddr)
					`REG_CTRL: ctrl_ff <= pwdata[`CTRL_EXT_EN];
					`REG_RISE: rise_ff <= wd_time;
					`REG_FALL: fall_ff <= wd_time;
					`REG_FLOOR: floor_ff <= wd;
					`REG_CEIL: ceil_ff <= wd;
					default: ;
				endcase
			end
		end
	end
endmodule

/* File: dv/setpoint_ramp_properties.sv */
// concurrent checks on the setpoint ramp pins
`timescale 1ns/1ps
module setpoint_ramp_properties #(
	parameter DEBOUNCE_CYCLES = 4,
	parameter COMBO_CYCLES = 50
) (
	input wire pclk, // clock
	input wire presetn, // reset, active low
	input wire [7:0] paddr, // apb address
	input wire psel, // apb select
	input wire penable, // apb access
	input wire [31:0] prdata_ff, // apb data
	input wire pready_ff, // apb ready
	input wire pslverr_ff, // apb error
	input wire raise_contact, // raise pin
	input wire lower_contact, // lower pin
	input wire enable_contact, // enable pin
	input wire output_type_jumper, // type strap
	input wire [15:0] setpoint_out_ff, // output level
	input wire output_type_ff, // type out
	input wire nv_write_req_ff // memory write
);
// ----
// helpers
// ----
// margins cover sync flops and the level pipeline
localparam int LIM_D = DEBOUNCE_CYCLES + 8;
localparam int LIM_B = DEBOUNCE_CYCLES + COMBO_CYCLES + 8;
reg [15:0] both_cnt_ff;
reg [15:0] open_cnt_ff;
reg [15:0] jmp_cnt_ff;
function automatic [15:0] bump(input [15:0] c, input on);
	bump = !on ? 16'h0 : ((c == 16'hffff) ? c : c + 16'h1);
endfunction
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		both_cnt_ff <= 16'h0;
		open_cnt_ff <= 16'h0;
		jmp_cnt_ff <= 16'h0;
	end
	else
	begin
		both_cnt_ff <= bump(both_cnt_ff, raise_contact && lower_contact);
		open_cnt_ff <= bump(open_cnt_ff, !enable_contact);
		jmp_cnt_ff <= bump(jmp_cnt_ff, output_type_jumper);
	end
end
// ----
// properties
// ----
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
property p_rdy_next; psel && !penable |=> pready_ff; endproperty
a_rdy_next: assert property (p_rdy_next) else $error("no ready after setup");
property p_rdy_one; pready_ff |=> !pready_ff; endproperty
a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
property p_err_map;
	pready_ff |-> pslverr_ff == (paddr > 8'h20 || paddr[1:0] != 2'h0);
endproperty
a_err_map: assert property (p_err_map) else $error("error flag wrong for address");
property p_rd_idle; !pready_ff |-> prdata_ff == 32'h0; endproperty
a_rd_idle: assert property (p_rd_idle) else $error("read data outside access");
property p_nv_one; nv_write_req_ff |=> !nv_write_req_ff [*8]; endproperty
a_nv_one: assert property (p_nv_one) else $error("memory writes too close");
property p_open_down;
	open_cnt_ff > LIM_D |-> setpoint_out_ff <= $past(setpoint_out_ff);
endproperty
a_open_down: assert property (p_open_down) else $error("rise while disabled");
property p_both_hold; both_cnt_ff > LIM_B |-> $stable(setpoint_out_ff); endproperty
a_both_hold: assert property (p_both_hold) else $error("moving while both held");
property p_type_on; jmp_cnt_ff > LIM_D |-> output_type_ff; endproperty
a_type_on: assert property (p_type_on) else $error("type not followed");
c_nv: cover property (nv_write_req_ff);
c_err: cover property (pready_ff && pslverr_ff);
c_combo: cover property (both_cnt_ff == LIM_B);
endmodule
bind pushbutton_setpoint_ramp setpoint_ramp_properties #(
	.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
	.COMBO_CYCLES(COMBO_CYCLES)
) u_props (
	.pclk(pclk),
	.presetn(presetn),
	.paddr(paddr),
	.psel(psel),
	.penable(penable),
	.prdata_ff(prdata_ff),
	.pready_ff(pready_ff),
	.pslverr_ff(pslverr_ff),
	.raise_contact(raise_contact),
	.lower_contact(lower_contact),
	.enable_contact(enable_contact),
	.output_type_jumper(output_type_jumper),
	.setpoint_out_ff(setpoint_out_ff),
	.output_type_ff(output_type_ff),
	.nv_write_req_ff(nv_write_req_ff)
);

/* File: dv/contact_panel.sv */
// operator contact panel model with chatter on every change
`timescale 1ns/1ps
module contact_panel (
	input wire pclk, // clock
	input wire [2:0] press, // wanted enable, lower, raise
	output reg [2:0] contact_ff // contacts as wired
);
reg [2:0] last_ff;
reg [2:0] old_ff;
reg [1:0] chat_ff;
initial
begin
	contact_ff = 3'h0;
	last_ff = 3'h0;
	old_ff = 3'h0;
	chat_ff = 2'h0;
end
// chatter stays shorter than the debounce window
always @(posedge pclk)
begin
	last_ff <= press;
	if (press != last_ff)
	begin
		old_ff <= last_ff;
		chat_ff <= 2'h3;
	end
	else if (chat_ff != 2'h0)
		chat_ff <= chat_ff - 2'h1;
	contact_ff <= chat_ff[0] ? old_ff : press;
end
endmodule

/* File: dv/pushbutton_setpoint_ramp_tb_top.sv */
// self-checking bench for the pushbutton setpoint ramp
`timescale 1ns/1ps
`include "setpoint_ramp_consts.vh"
module pushbutton_setpoint_ramp_tb_top;
reg pclk, presetn, psel, penable, pwrite, output_type_jumper, nv_restore_valid;
reg [7:0] paddr;
reg [31:0] pwdata;
reg [15:0] external_scale_input, nv_restore_data;
reg [2:0] press;
wire raise_contact, lower_contact, enable_contact;
wire pready_ff, pslverr_ff, output_type_ff, nv_write_req_ff;
wire [31:0] prdata_ff;
wire [15:0] setpoint_out_ff, nv_write_data_ff;
integer err_count, checks_done, n;
reg [31:0] q;
reg e;
reg [15:0] held;
contact_panel u_panel (
	.pclk(pclk),
	.press(press),
	.contact_ff({enable_contact, lower_contact, raise_contact})
);
pushbutton_setpoint_ramp #(
	.DEBOUNCE_CYCLES(4),
	.COMBO_CYCLES(50),
	.NV_IDLE_CYCLES(100)
) u_dut (
	.pclk(pclk),
	.presetn(presetn),
	.paddr(paddr),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.pwdata(pwdata),
	.prdata_ff(prdata_ff),
	.pready_ff(pready_ff),
	.pslverr_ff(pslverr_ff),
	.raise_contact(raise_contact),
	.lower_contact(lower_contact),
	.enable_contact(enable_contact),
	.output_type_jumper(output_type_jumper),
	.external_scale_input(external_scale_input),
	.nv_restore_valid(nv_restore_valid),
	.nv_restore_data(nv_restore_data),
	.setpoint_out_ff(setpoint_out_ff),
	.output_type_ff(output_type_ff),
	.nv_write_req_ff(nv_write_req_ff),
	.nv_write_data_ff(nv_write_data_ff)
);
initial
begin
	pclk = 1'b0;
	forever #50 pclk = ~pclk;
end
task automatic run(input integer c);
	repeat (c) @(posedge pclk);
endtask
task chk(input string nm, input [31:0] s, input [31:0] x);
	checks_done = checks_done + 1;
	if (s !== x)
	begin
		err_count = err_count + 1;
		$display("ERROR %s expected %h seen %h", nm, x, s);
	end
endtask
task bus(input w, input [7:0] a, input [31:0] d);
	@(posedge pclk);
	psel <= 1'b1;
	penable <= 1'b0;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'b1;
	@(posedge pclk);
	while (pready_ff !== 1'b1) @(posedge pclk);
	q = prdata_ff;
	e = pslverr_ff;
	psel <= 1'b0;
	penable <= 1'b0;
endtask
task rd(input [7:0] a, input [31:0] x);
	bus(1'b0, a, 32'h0);
	chk("register", q, x);
endtask
task sp(input [15:0] x);
	chk("level", {16'h0, setpoint_out_ff}, {16'h0, x});
endtask
task done(input string nm);
	$display("test %s finished", nm);
endtask
task t_regs;
	rd(`REG_CTRL, 32'h0);
	rd(`REG_RISE, 32'h2710);
	rd(`REG_FALL, 32'h2710);
	rd(`REG_CEIL, 32'hffff);
	rd(`REG_FLOOR, 32'h0);
	bus(1'b1, `REG_RISE, 32'hffff);
	rd(`REG_RISE, {16'h0, `RAMP_MAX_MS});
	bus(1'b0, 8'h24, 32'h0);
	chk("unmapped", {31'h0, e}, 32'h1);
	bus(1'b1, `REG_RISE, 32'h0);
	bus(1'b1, `REG_FALL, 32'h0);
	bus(1'b1, `REG_FLOOR, 32'h40);
	bus(1'b1, `REG_CEIL, 32'h40);
	done("regs");
endtask
task t_open;
	press <= 3'b001;
	run(60);
	rd(`REG_HELD, 32'h10);
	rd(`REG_STATUS, 32'h1);
	sp(16'h10);
	press <= 3'b100;
	run(30);
	done("open");
endtask
task t_raise;
	press <= 3'b101;
	run(120);
	press <= 3'b100;
	run(20);
	sp(16'h40);
	n = 0;
	while (nv_write_req_ff !== 1'b1 && n < 400)
	begin
		@(posedge pclk);
		n = n + 1;
	end
	chk("nv pulse", {31'h0, n < 400}, 32'h1);
	chk("nv data", {16'h0, nv_write_data_ff}, 32'h40);
	done("raise");
endtask
task t_lower;
	press <= 3'b110;
	run(20);
	press <= 3'b100;
	run(20);
	held = setpoint_out_ff;
	chk("lower", {31'h0, held < 16'h40 && held > 16'h10}, 32'h1);
	run(40);
	sp(held);
	press <= 3'b000;
	run(100);
	sp(16'h10);
	press <= 3'b100;
	run(100);
	sp(held);
	done("lower enable");
endtask
task t_combo;
	press <= 3'b111;
	run(30);
	sp(held);
	run(50);
	sp(16'h10);
	press <= 3'b101;
	run(80);
	press <= 3'b000;
	run(100);
	press <= 3'b011;
	run(100);
	press <= 3'b000;
	run(20);
	press <= 3'b100;
	run(100);
	sp(16'h10);
	done("combo");
endtask
task t_restore;
	press <= 3'b000;
	run(60);
	nv_restore_data <= 16'h30;
	nv_restore_valid <= 1'b1;
	@(posedge pclk);
	nv_restore_valid <= 1'b0;
	run(20);
	sp(16'h10);
	rd(`REG_HELD, 32'h30);
	rd(`REG_LEVEL, 32'h10);
	press <= 3'b100;
	run(100);
	sp(16'h30);
	done("restore");
endtask
task t_scale;
	bus(1'b1, `REG_CTRL, 32'h1);
	external_scale_input <= 16'h8000;
	run(5);
	sp(16'h18);
	rd(`REG_OUT, 32'h18);
	output_type_jumper <= 1'b1;
	run(30);
	chk("type", {31'h0, output_type_ff}, 32'h1);
	done("scale type");
endtask
// 10 ms full scale is 65535 codes per 100000 cycles: about 19 codes in 30
task t_rate;
	bus(1'b1, `REG_FALL, 32'ha);
	bus(1'b1, `REG_RISE, 32'ha);
	press <= 3'b110;
	run(30);
	press <= 3'b100;
	run(20);
	bus(1'b0, `REG_HELD, 32'h0);
	held = q[15:0];
	chk("fall rate", {31'h0, 16'h30 - held > 16'h10 && 16'h30 - held < 16'h16}, 32'h1);
	press <= 3'b101;
	run(30);
	press <= 3'b100;
	run(20);
	bus(1'b0, `REG_HELD, 32'h0);
	chk("rise rate", {31'h0, q[15:0] - held > 16'h10 && q[15:0] - held < 16'h16}, 32'h1);
	done("rate");
endtask
task print_verdict;
	$display("checks %0d mismatches %0d", checks_done, err_count);
	if (err_count == 0 && checks_done > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
endtask
initial
begin
	err_count = 0;
	checks_done = 0;
	presetn = 1'b0;
	psel = 1'b0;
	penable = 1'b0;
	pwrite = 1'b0;
	paddr = 8'h0;
	pwdata = 32'h0;
	press = 3'b100;
	output_type_jumper = 1'b0;
	external_scale_input = 16'hffff;
	nv_restore_valid = 1'b0;
	nv_restore_data = 16'h0;
	run(6);
	presetn <= 1'b1;
	run(12);
	t_regs;
	t_open;
	t_raise;
	t_lower;
	t_combo;
	t_restore;
	t_scale;
	t_rate;
	print_verdict;
end
// run is about 1400 cycles; the margin absorbs slow ramps
initial
begin
	run(20000);
	err_count = err_count + 1;
	print_verdict;
end
endmodule
